// *** design/obm_master.sv ***
// Device end: requests the operand bus and runs strobed bus cycles
// Function
// - Drive request low when bus needed
// - Float request while test held low
// - Take bus only after grant
// - Other master holds bus-in-use while using
// - Grant acknowledge low while bus owner
// - Others stay off while acknowledge low
// - Release acknowledge to float, not high
// - Instruction qualifier low only on fetch
// - Cycle completes only after transfer acknowledge
// - Acknowledge may be tied low
// - Memory/IO qualifier high memory, low IO
// - Float memory/IO qualifier when not owner
// - Read/write high read, low write
// - Float read/write when not owner
// - Address strobe low on valid address, driven high in the end state while owner, else float
// - Data strobe low on valid data, driven high in address and end states while owner, else float
// - Test mode floats all but clock outputs
`include "obm_cfg.svh"
module obm_master (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // Test mode, active low
    input  wire logic        test_n_i,
    // Pins
    obm_if.master            bus,
    // Clock outputs
    output logic             osc_clock_out_o,
    output logic             sys_clock_out_o,
    // Cycle request
    input  wire logic        cyc_valid_i,
    input  wire logic [1:0]  cyc_kind_i,
    input  wire obm_pkg::obm_addr_t cyc_addr_i,
    input  wire obm_pkg::obm_data_t cyc_wdata_i,
    input  wire logic        keep_bus_i,
    output logic             cyc_ready_o,
    output logic             cyc_done_o,
    output obm_pkg::obm_data_t cyc_rdata_o,
    output logic             owner_o
);
    import obm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Three-flop synchronisers for the partner pins
    logic [2:0] gnt_s, use_s, ack_s;
    logic gnt_q, use_q, ack_q;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gnt_s <= 3'h7;
            use_s <= 3'h7;
            ack_s <= 3'h7;
            gnt_q <= 1'b1;
            use_q <= 1'b1;
            ack_q <= 1'b1;
        end else begin
            gnt_s <= {gnt_s[1:0], bus.bus_grant_n};
            use_s <= {use_s[1:0], bus.bus_in_use_n};
            ack_s <= {ack_s[1:0], bus.transfer_ack_n};
            if (gnt_s[2] == gnt_s[1])
                gnt_q <= gnt_s[2];
            if (use_s[2] == use_s[1])
                use_q <= use_s[2];
            if (ack_s[2] == ack_s[1])
                ack_q <= ack_s[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ownership and bus cycle sequencer
    obm_state_t st_r, st_nxt;
    logic [1:0] kind_r, kind_nxt;
    obm_addr_t  addr_r, addr_nxt;
    obm_data_t  wdat_r, wdat_nxt;
    obm_data_t  rdat_r, rdat_nxt;
    logic       done_r, done_nxt;
    logic       ds_held_r, ds_held_nxt;
    logic       take;
    logic       owner;

    assign take = st_r == OBM_IDLE && cyc_valid_i && test_n_i;

    always_comb begin
        st_nxt   = st_r;
        kind_nxt = kind_r;
        addr_nxt = addr_r;
        wdat_nxt = wdat_r;
        rdat_nxt = rdat_r;
        done_nxt = 1'b0;
        // Data strobe stands two cycles at least, so a slave behind
        // synchronisers still sees it when acknowledge is tied low
        ds_held_nxt = st_r == OBM_DATA;
        case (st_r)
            OBM_IDLE: begin
                if (take) begin
                    kind_nxt = cyc_kind_i;
                    addr_nxt = cyc_addr_i;
                    wdat_nxt = cyc_wdata_i;
                    st_nxt   = OBM_REQ;
                end
            end
            OBM_REQ: begin
                if (!gnt_q && use_q)
                    st_nxt = OBM_ADDR;
            end
            OBM_ADDR: st_nxt = OBM_DATA;
            OBM_DATA: begin
                if (!ack_q && ds_held_r) begin
                    rdat_nxt = bus.data_so;
                    done_nxt = 1'b1;
                    st_nxt   = OBM_END;
                end
            end
            OBM_END: begin
                if (keep_bus_i && cyc_valid_i && test_n_i) begin
                    kind_nxt = cyc_kind_i;
                    addr_nxt = cyc_addr_i;
                    wdat_nxt = cyc_wdata_i;
                    st_nxt   = OBM_ADDR;
                end else begin
                    st_nxt = OBM_GIVE;
                end
            end
            // Wait for the stale grant to be withdrawn before asking again
            OBM_GIVE: begin
                if (gnt_q)
                    st_nxt = OBM_IDLE;
            end
            default: st_nxt = OBM_IDLE;
        endcase
        if (!test_n_i)
            st_nxt = OBM_IDLE;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r   <= OBM_IDLE;
            kind_r <= `OBM_CYC_MEMRD;
            addr_r <= 16'h0000;
            wdat_r <= 16'h0000;
            rdat_r <= 16'h0000;
            done_r <= 1'b0;
            ds_held_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            kind_r <= kind_nxt;
            addr_r <= addr_nxt;
            wdat_r <= wdat_nxt;
            rdat_r <= rdat_nxt;
            done_r <= done_nxt;
            ds_held_r <= ds_held_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive; ownership spans address, data and end states
    assign owner = test_n_i && (st_r == OBM_ADDR || st_r == OBM_DATA || st_r == OBM_END);

    assign bus.bus_request_n_o  = 1'b0;
    assign bus.bus_request_n_oe = test_n_i && st_r == OBM_REQ;
    assign bus.grant_ack_n_o    = 1'b0;
    assign bus.grant_ack_n_oe   = owner;
    assign bus.operand_not_instruction_o  = kind_r != `OBM_CYC_INSTR;
    assign bus.operand_not_instruction_oe = owner;
    assign bus.mem_not_io_o     = kind_r != `OBM_CYC_IO;
    assign bus.mem_not_io_oe    = owner;
    assign bus.read_not_write_o = kind_r != `OBM_CYC_MEMWR;
    assign bus.read_not_write_oe = owner;
    assign bus.addr_strobe_n_o  = !(st_r == OBM_ADDR || st_r == OBM_DATA);
    assign bus.addr_strobe_n_oe = owner;
    assign bus.data_strobe_n_o  = st_r != OBM_DATA;
    assign bus.data_strobe_n_oe = owner;
    assign bus.addr_o           = addr_r;
    assign bus.addr_oe          = owner;
    assign bus.data_mo          = wdat_r;
    assign bus.data_moe         = owner && kind_r == `OBM_CYC_MEMWR;

    // Clock outputs stay live in test mode
    assign osc_clock_out_o = clk_i;
    assign sys_clock_out_o = clk_i;
    assign cyc_ready_o     = take;
    assign cyc_done_o      = done_r;
    assign cyc_rdata_o     = rdat_r;
    assign owner_o         = owner;
endmodule

// *** design/obm_partner.sv ***
// Arbiter and slave end: grants the bus and acknowledges transfers
`include "obm_cfg.svh"
module obm_partner (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // Pins
    obm_if.partner           bus,
    // User side
    input  wire logic        other_busy_i,
    input  wire logic        no_wait_i,
    input  wire logic [3:0]  wait_cycles_i,
    input  wire obm_pkg::obm_data_t rd_data_i,
    output logic             wr_valid_o,
    output obm_pkg::obm_addr_t wr_addr_o,
    output obm_pkg::obm_data_t wr_data_o
);
    import obm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Three-flop input synchronisers
    logic [2:0] req_s, gack_s, as_s, ds_s;
    logic req_q, gack_q, as_q, ds_q;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            req_s  <= 3'h7;
            gack_s <= 3'h7;
            as_s   <= 3'h7;
            ds_s   <= 3'h7;
            req_q  <= 1'b1;
            gack_q <= 1'b1;
            as_q   <= 1'b1;
            ds_q   <= 1'b1;
        end else begin
            req_s  <= {req_s[1:0], !(bus.bus_request_n_oe && !bus.bus_request_n_o)};
            gack_s <= {gack_s[1:0], !(bus.grant_ack_n_oe && !bus.grant_ack_n_o)};
            as_s   <= {as_s[1:0], !(bus.addr_strobe_n_oe && !bus.addr_strobe_n_o)};
            ds_s   <= {ds_s[1:0], !(bus.data_strobe_n_oe && !bus.data_strobe_n_o)};
            if (req_s[2] == req_s[1])
                req_q <= req_s[2];
            if (gack_s[2] == gack_s[1])
                gack_q <= gack_s[2];
            if (as_s[2] == as_s[1])
                as_q <= as_s[2];
            if (ds_s[2] == ds_s[1])
                ds_q <= ds_s[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Arbiter: grant on request, hold bus-in-use for the other master
    obm_arb_t   arb_r, arb_nxt;
    logic [3:0] wcnt_r, wcnt_nxt;
    logic       ack_r, ack_nxt;
    logic       wrv_r, wrv_nxt;
    obm_addr_t  wra_r, wra_nxt;
    obm_data_t  wrd_r, wrd_nxt;
    always_comb begin
        arb_nxt  = arb_r;
        wcnt_nxt = wcnt_r;
        ack_nxt  = ack_r;
        wrv_nxt  = 1'b0;
        wra_nxt  = wra_r;
        wrd_nxt  = wrd_r;
        case (arb_r)
            OBA_IDLE: begin
                if (other_busy_i && gack_q)
                    arb_nxt = OBA_BUSY;
                else if (!req_q)
                    arb_nxt = OBA_GRANT;
            end
            OBA_GRANT: begin
                if (req_q && gack_q)
                    arb_nxt = OBA_IDLE;
            end
            OBA_BUSY: begin
                if (!other_busy_i)
                    arb_nxt = OBA_IDLE;
            end
            default: arb_nxt = OBA_IDLE;
        endcase
        // Slave acknowledge after the wait count
        if (!ds_q && !ack_r) begin
            if (wcnt_r >= wait_cycles_i) begin
                ack_nxt = 1'b1;
                wcnt_nxt = 4'h0;
                if (!bus.read_not_write_o) begin
                    wrv_nxt = 1'b1;
                    wra_nxt = bus.addr_o;
                    wrd_nxt = bus.data_mo;
                end
            end else begin
                wcnt_nxt = wcnt_r + 4'h1;
            end
        end else if (ds_q && as_q) begin
            ack_nxt  = 1'b0;
            wcnt_nxt = 4'h0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            arb_r  <= OBA_IDLE;
            wcnt_r <= 4'h0;
            ack_r  <= 1'b0;
            wrv_r  <= 1'b0;
            wra_r  <= 16'h0000;
            wrd_r  <= 16'h0000;
        end else begin
            arb_r  <= arb_nxt;
            wcnt_r <= wcnt_nxt;
            ack_r  <= ack_nxt;
            wrv_r  <= wrv_nxt;
            wra_r  <= wra_nxt;
            wrd_r  <= wrd_nxt;
        end
    end

    // Pin drive
    assign bus.bus_grant_n    = (arb_r != OBA_GRANT);
    assign bus.bus_in_use_n   = (arb_r != OBA_BUSY);
    assign bus.transfer_ack_n = no_wait_i ? 1'b0 : !ack_r;
    assign bus.data_so        = rd_data_i;
    assign bus.data_soe       = !ds_q && bus.read_not_write_o;
    assign wr_valid_o         = wrv_r;
    assign wr_addr_o          = wra_r;
    assign wr_data_o          = wrd_r;
endmodule

// *** inc/obm_cfg.svh ***
// Constants for the operand bus master interface
`ifndef OBM_CFG_SVH
`define OBM_CFG_SVH
`define OBM_DATA_W   16
`define OBM_ADDR_W   16
`define OBM_CYC_INSTR 2'h0
`define OBM_CYC_MEMRD 2'h1
`define OBM_CYC_MEMWR 2'h2
`define OBM_CYC_IO    2'h3
`endif

// *** inc/obm_if.sv ***
// Pin bundle between the bus master and the arbiter and slave end
interface obm_if;
    // Master pins, each with output enable
    logic                  bus_request_n_o, bus_request_n_oe;
    logic                  grant_ack_n_o, grant_ack_n_oe;
    logic                  operand_not_instruction_o, operand_not_instruction_oe;
    logic                  mem_not_io_o, mem_not_io_oe;
    logic                  read_not_write_o, read_not_write_oe;
    logic                  addr_strobe_n_o, addr_strobe_n_oe;
    logic                  data_strobe_n_o, data_strobe_n_oe;
    logic [15:0]           addr_o;
    logic                  addr_oe;
    logic [15:0]           data_mo;
    logic                  data_moe;
    // Partner pins
    logic                  bus_grant_n;
    logic                  bus_in_use_n;
    logic                  transfer_ack_n;
    logic [15:0]           data_so;
    logic                  data_soe;
    modport master (
        output bus_request_n_o, bus_request_n_oe, grant_ack_n_o, grant_ack_n_oe,
        output operand_not_instruction_o, operand_not_instruction_oe,
        output mem_not_io_o, mem_not_io_oe, read_not_write_o, read_not_write_oe,
        output addr_strobe_n_o, addr_strobe_n_oe, data_strobe_n_o, data_strobe_n_oe,
        output addr_o, addr_oe, data_mo, data_moe,
        input  bus_grant_n, bus_in_use_n, transfer_ack_n, data_so, data_soe
    );
    modport partner (
        input  bus_request_n_o, bus_request_n_oe, grant_ack_n_o, grant_ack_n_oe,
        input  operand_not_instruction_o, operand_not_instruction_oe,
        input  mem_not_io_o, mem_not_io_oe, read_not_write_o, read_not_write_oe,
        input  addr_strobe_n_o, addr_strobe_n_oe, data_strobe_n_o, data_strobe_n_oe,
        input  addr_o, addr_oe, data_mo, data_moe,
        output bus_grant_n, bus_in_use_n, transfer_ack_n, data_so, data_soe
    );
endinterface

// *** inc/obm_pkg.sv ***
// Types for the operand bus master interface
`include "obm_cfg.svh"
package obm_pkg;
    typedef logic [`OBM_DATA_W-1:0] obm_data_t;
    typedef logic [`OBM_ADDR_W-1:0] obm_addr_t;
    typedef enum logic [5:0] {
        OBM_IDLE  = 6'b00_0001,
        OBM_REQ   = 6'b00_0010,
        OBM_ADDR  = 6'b00_0100,
        OBM_DATA  = 6'b00_1000,
        OBM_END   = 6'b01_0000,
        OBM_GIVE  = 6'b10_0000
    } obm_state_t;
    typedef enum logic [2:0] {
        OBA_IDLE = 3'b001,
        OBA_GRANT = 3'b010,
        OBA_BUSY = 3'b100
    } obm_arb_t;
endpackage

// *** tb/obm_chk.sv ***
// Assertions on the pins between the bus master and its partner
module obm_chk (
    // Clock, reset and test mode
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic test_n_i,
    // Master pins
    input wire logic bus_request_n_o,
    input wire logic bus_request_n_oe,
    input wire logic grant_ack_n_o,
    input wire logic grant_ack_n_oe,
    input wire logic operand_not_instruction_o,
    input wire logic mem_not_io_o,
    input wire logic mem_not_io_oe,
    input wire logic read_not_write_o,
    input wire logic read_not_write_oe,
    input wire logic addr_strobe_n_o,
    input wire logic addr_strobe_n_oe,
    input wire logic data_strobe_n_o,
    input wire logic data_strobe_n_oe,
    // Partner pins
    input wire logic bus_grant_n,
    input wire logic bus_in_use_n,
    input wire logic transfer_ack_n
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic as_on;
    logic ds_on;
    ////////////////////////////////////////////////////////////////////////////
    // Strobes driven and active
    assign as_on = addr_strobe_n_oe && !addr_strobe_n_o;
    assign ds_on = data_strobe_n_oe && !data_strobe_n_o;
    ////////////////////////////////////////////////////////////////////////////
    a_test_floats: assert property (!test_n_i && $past(!test_n_i) |->
        !(bus_request_n_oe || grant_ack_n_oe || addr_strobe_n_oe || data_strobe_n_oe))
        else $error("pins driven in test mode");
    a_ack_after_grant: assert property ($rose(grant_ack_n_oe) |->
        !bus_grant_n && bus_in_use_n) else $error("ownership without grant");
    a_ack_low_only: assert property (grant_ack_n_oe |-> !grant_ack_n_o)
        else $error("grant acknowledge driven high");
    a_req_withdrawn: assert property ($rose(grant_ack_n_oe) |->
        ##[0:8] (!bus_request_n_oe || bus_request_n_o)) else $error("request kept");
    a_float_not_owner: assert property (!grant_ack_n_oe |->
        !(mem_not_io_oe || read_not_write_oe || addr_strobe_n_oe || data_strobe_n_oe))
        else $error("control pin driven while not owner");
    a_quals_with_as: assert property (as_on |->
        mem_not_io_oe && read_not_write_oe && grant_ack_n_oe) else $error("qualifier off");
    a_fetch_mem_read: assert property (as_on && !operand_not_instruction_o |->
        mem_not_io_o && read_not_write_o) else $error("fetch not a memory read");
    a_ds_after_as: assert property (ds_on && !$past(ds_on) |->
        as_on && $past(as_on)) else $error("data strobe before address strobe");
    a_ds_waits_ack: assert property ((ds_on && transfer_ack_n)[*6] |=> ds_on)
        else $error("cycle ended without acknowledge");
    a_ds_ends_ack: assert property (ds_on && !transfer_ack_n |-> ##[1:10] !ds_on)
        else $error("strobe held after acknowledge");
endmodule

// *** tb/tb.sv ***
// Bench joining the bus master to its arbiter and slave end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import obm_pkg::*;
    typedef struct {logic [1:0] k; obm_addr_t a; obm_data_t wd; obm_data_t rd;
        logic nw; logic [3:0] wt;} obm_row_t;
    logic       clk_i = 1'h0;
    logic       rstn_i = 1'h0;
    logic       test_n_i = 1'h1;
    logic       cyc_valid_i = 1'h0;
    logic [1:0] cyc_kind_i = 2'h0;
    obm_addr_t  cyc_addr_i = 16'h0000;
    obm_data_t  cyc_wdata_i = 16'h0000;
    logic       other_busy_i = 1'h0;
    logic       no_wait_i = 1'h0;
    logic [3:0] wait_cycles_i = 4'h0;
    obm_data_t  rd_data_i = 16'h0000;
    logic       cyc_ready_o, cyc_done_o, owner_o, osc_o, sys_o, wr_valid_o;
    obm_data_t  cyc_rdata_o, wr_data_o, wd_seen;
    obm_addr_t  wr_addr_o, a_seen, wa_seen;
    logic [2:0] q_seen;
    logic       req_seen, wr_seen;
    int         n_errors = 0;
    int         n_checks = 0;
    int         n_cyc = 0;
    obm_row_t   rows [6] = '{'{2'h0, 16'h0010, 16'h0000, 16'ha5c3, 1'h0, 4'h1},
        '{2'h1, 16'hffff, 16'h0000, 16'h5a3c, 1'h0, 4'h0},
        '{2'h2, 16'h8001, 16'h1234, 16'h0000, 1'h0, 4'h2},
        '{2'h3, 16'h0000, 16'h0000, 16'hffff, 1'h0, 4'hf},
        '{2'h1, 16'h7ffe, 16'h0000, 16'h0001, 1'h1, 4'h0},
        '{2'h2, 16'h00ff, 16'hffff, 16'h0000, 1'h1, 4'h0}};
    ////////////////////////////////////////////////////////////////////////////
    // Clock and instances
    always #2 clk_i = ~clk_i;
    obm_if bus ();
    obm_master obm_master_i (.clk_i(clk_i), .rstn_i(rstn_i), .test_n_i(test_n_i), .bus(bus),
        .osc_clock_out_o(osc_o), .sys_clock_out_o(sys_o), .cyc_valid_i(cyc_valid_i),
        .cyc_kind_i(cyc_kind_i), .cyc_addr_i(cyc_addr_i), .cyc_wdata_i(cyc_wdata_i),
        .keep_bus_i(1'h0), .cyc_ready_o(cyc_ready_o), .cyc_done_o(cyc_done_o),
        .cyc_rdata_o(cyc_rdata_o), .owner_o(owner_o));
    obm_partner obm_partner_i (.clk_i(clk_i), .rstn_i(rstn_i), .bus(bus),
        .other_busy_i(other_busy_i), .no_wait_i(no_wait_i), .wait_cycles_i(wait_cycles_i),
        .rd_data_i(rd_data_i), .wr_valid_o(wr_valid_o), .wr_addr_o(wr_addr_o),
        .wr_data_o(wr_data_o));
    obm_chk obm_chk_i (.clk_i(clk_i), .rstn_i(rstn_i), .test_n_i(test_n_i),
        .bus_request_n_o(bus.bus_request_n_o), .bus_request_n_oe(bus.bus_request_n_oe),
        .grant_ack_n_o(bus.grant_ack_n_o), .grant_ack_n_oe(bus.grant_ack_n_oe),
        .operand_not_instruction_o(bus.operand_not_instruction_o),
        .mem_not_io_o(bus.mem_not_io_o), .mem_not_io_oe(bus.mem_not_io_oe),
        .read_not_write_o(bus.read_not_write_o), .read_not_write_oe(bus.read_not_write_oe),
        .addr_strobe_n_o(bus.addr_strobe_n_o), .addr_strobe_n_oe(bus.addr_strobe_n_oe),
        .data_strobe_n_o(bus.data_strobe_n_o), .data_strobe_n_oe(bus.data_strobe_n_oe),
        .bus_grant_n(bus.bus_grant_n), .bus_in_use_n(bus.bus_in_use_n),
        .transfer_ack_n(bus.transfer_ack_n));
    ////////////////////////////////////////////////////////////////////////////
    // Wire watcher and hang limit
    always @(negedge clk_i) begin
        if (bus.addr_strobe_n_oe && !bus.addr_strobe_n_o) begin
            q_seen = {bus.operand_not_instruction_o, bus.mem_not_io_o, bus.read_not_write_o};
            a_seen = bus.addr_o;
        end
        if (bus.bus_request_n_oe && !bus.bus_request_n_o) req_seen = 1'h1;
        if (wr_valid_o) begin
            wr_seen = 1'h1;
            wa_seen = wr_addr_o;
            wd_seen = wr_data_o;
        end
        n_cyc++;
        if (n_cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic do_reset();
        @(negedge clk_i);
        rstn_i = 1'h0;
        @(negedge clk_i);
        chk({bus.bus_request_n_oe, bus.grant_ack_n_oe, bus.addr_strobe_n_oe,
            bus.data_strobe_n_oe, owner_o}, 0, "pins not floating in reset");
        @(negedge clk_i);
        rstn_i = 1'h1;
    endtask
    task automatic do_cyc(input obm_row_t r);
        int t;
        @(negedge clk_i);
        {no_wait_i, wait_cycles_i, rd_data_i} = {r.nw, r.wt, r.rd};
        {cyc_kind_i, cyc_addr_i, cyc_wdata_i} = {r.k, r.a, r.wd};
        {cyc_valid_i, req_seen, wr_seen} = 3'h4;
        #1;
        for (t = 0; t < 200 && cyc_ready_o !== 1'h1; t++) @(negedge clk_i);
        @(negedge clk_i);
        cyc_valid_i = 1'h0;
        for (t = 0; t < 300 && cyc_done_o !== 1'h1; t++) @(negedge clk_i);
        chk(cyc_done_o, 1, "cycle never completed");
        chk(req_seen, 1, "no bus request");
        chk(q_seen, {r.k != 2'h0, r.k != 2'h3, r.k != 2'h2}, "qualifiers");
        chk(a_seen, r.a, "address on strobe");
        if (r.k != 2'h2) chk(cyc_rdata_o, r.rd, "read data");
        repeat (6) @(negedge clk_i);
        if (r.k == 2'h2) chk({wr_seen, wa_seen, wd_seen}, {1'h1, r.a, r.wd}, "write");
        $display("cycle kind %0d done", r.k);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        do_reset();
        foreach (rows[i]) do_cyc(rows[i]);
        // Another master holds the bus for a while
        other_busy_i = 1'h1;
        fork
            do_cyc(rows[1]);
            repeat (30) begin
                @(negedge clk_i);
                chk(bus.grant_ack_n_oe, 0, "owner while bus in use");
            end
        join_any
        other_busy_i = 1'h0;
        wait fork;
        $display("busy test done");
        // Test mode refuses requests and floats the pins
        test_n_i = 1'h0;
        cyc_valid_i = 1'h1;
        repeat (8) begin
            @(negedge clk_i);
            chk({cyc_ready_o, bus.bus_request_n_oe, osc_o, sys_o}, 0, "test mode");
        end
        {cyc_valid_i, test_n_i} = 2'h1;
        do_reset();
        $display("test mode done");
        // Reset in the middle of a slow cycle
        {cyc_valid_i, no_wait_i, wait_cycles_i} = 6'h2f;
        repeat (2) @(negedge clk_i);
        cyc_valid_i = 1'h0;
        repeat (14) @(negedge clk_i);
        chk({bus.grant_ack_n_oe, owner_o}, 2'h3, "owner mid cycle");
        do_reset();
        do_cyc(rows[0]);
        $display("reset test done");
        tally_and_finish();
    end
endmodule
